//--- rtl/errlog_pkg.sv
// Constants for the bus error capture log block.
// Assumes one core clock and a synchronous active-low sticky reset.
// Functional notes
// RL1: Capture first recoverable bus error at response.
// RL2: Time-out error logs address, write, read only.
// RL3: Log valid only while its status bit set.
// RL4: Bits 76..70 hold origin, type, line flags.
// RL5: Bits 69..67 hold defer, sequencing, modified hit.
// RL6: Bits 66..63 hold hardfail, defer, nodata, retry.
// RL7: Length, byte enables, target ready, defer id.
// RL8: Address 43:3 in 40:0, not writable.
// RL9: Forwarded write address equals link packet address.
// RL10: Low address bits may be cleared for bursts.
// RL11: First fatal bus error captured, same layout.
// RL12: Synch error logs address, write, read only.
// RL13: Fatal log valid ten cycles after response.
// RL14: Capture first recoverable protocol or config error.
// RL15: Protocol log holds 64-bit header.
// RL16: Loaded log holds until status bit cleared.
// RL17: Reserved bits read zero, writes ignored.
// RL18: Reset to zero; later errors never overwrite.
package errlog_pkg;
   // ----------------------------------------
   // Register offsets (32-bit configuration words)
   // ----------------------------------------
   localparam logic [7:0] OFS_PROTO_LO = 8'h40;
   localparam logic [7:0] OFS_PROTO_HI = 8'h44;
   localparam logic [7:0] OFS_RECBUS_0 = 8'hcc;
   localparam logic [7:0] OFS_RECBUS_1 = 8'hd0;
   localparam logic [7:0] OFS_RECBUS_2 = 8'hd4;
   localparam logic [7:0] OFS_FATBUS_0 = 8'hdc;
   localparam logic [7:0] OFS_FATBUS_1 = 8'he0;
   localparam logic [7:0] OFS_FATBUS_2 = 8'he4;
   // ----------------------------------------
   // Bus log field layout
   // ----------------------------------------
   localparam int BUS_LOG_W = 96;
   localparam int PROTO_LOG_W = 64;
   localparam int CTL_W = 36;
   localparam int POS_INIT = 76;
   localparam int POS_WRITE = 75;
   localparam int POS_READ = 74;
   localparam int POS_SPECIAL = 73;
   localparam int POS_CLEAN_LINE_REPLACE = 72;
   localparam int POS_TRANSLATION_PURGE = 71;
   localparam int POS_LINE_INVALIDATE = 70;
   localparam int POS_DEFERRED = 69;
   localparam int POS_SEQUENCING = 68;
   localparam int POS_MOD_HIT = 67;
   localparam int POS_RSP_HARDFAIL = 66;
   localparam int POS_RSP_DEFER = 65;
   localparam int POS_RSP_NODATA = 64;
   localparam int POS_RSP_RETRY = 63;
   localparam int POS_LEN_LO = 60;
   localparam int POS_BE_LO = 52;
   localparam int POS_TARGET_READY_SIGNAL = 51;
   localparam int POS_DID_LO = 41;
   localparam int POS_ADDR_LO = 0;
   localparam int ADDR_W = 41;
   localparam logic [BUS_LOG_W-1:0] BUS_LOG_RESET = 96'h0;
   localparam logic [PROTO_LOG_W-1:0] PROTO_LOG_RESET = 64'h0;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0;
   // Burst alignment: how many low address bits to clear (0..4)
   localparam int BURST_CLR_MAX = 4;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int FATAL_SETTLE_CYC = 10;
endpackage

//--- rtl/errlog_capture.sv
// One capture-once log register with a hold-until-released latch.
// Assumes load and release come from logic on the same clock.
module errlog_capture #(
   parameter int WIDTH = 96
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_load,
   input wire logic [WIDTH-1:0] i_data,
   input wire logic i_release,
   output logic o_full,
   output logic [WIDTH-1:0] o_data
);
   logic full_reg;
   logic [WIDTH-1:0] data_reg;
   wire take = i_load && !full_reg;
   // Release wins over a load while held: the log is released with its data kept, and that error is not taken
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         full_reg <= 1'b0;
         data_reg <= '0;
      end else begin
         if (take) begin // see RL18
            data_reg <= i_data;
            full_reg <= 1'b1;
         end else if (i_release) begin // see RL16
            full_reg <= 1'b0;
         end
      end
   end
   assign o_full = full_reg;
   assign o_data = data_reg;

   a_hold_when_full: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see RL16
      full_reg && !i_release |=> $stable(data_reg))
      else $error("log changed while held");
   a_first_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n) // see RL18
      full_reg && i_load |=> data_reg == $past(data_reg))
      else $error("later error overwrote log");
endmodule

//--- rtl/errlog_settle.sv
// Down-counter that marks a log valid a fixed number of cycles after capture.
// Assumes the start pulse is one cycle wide and on the same clock.
module errlog_settle #(
   parameter int CYCLES = 10
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic i_held,
   output logic o_ready
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;
   initial begin
      if (CYCLES < 1) $error("settle count must be at least one");
   end
   assign cnt_next = i_start ? CW'(CYCLES) : (cnt_reg != '0 ? cnt_reg - 1'b1 : cnt_reg);
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt_reg <= '0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
   // Ready only once the count ran out and the log is still held
   assign o_ready = i_held && cnt_reg == '0 && !i_start; // see RL13
endmodule

//--- rtl/bus_error_capture_log.sv
// Error-capture logs for bus and node-link errors, read over config space.
// Assumes snoop inputs are sampled on the core clock in the response phase
// and that the first-error status logic issues one-cycle release pulses.
module bus_error_capture_log
   import errlog_pkg::*;
#(
   parameter int SETTLE_CYCLES = errlog_pkg::FATAL_SETTLE_CYC,
   parameter int BURST_CLR = 0
) (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   // Response-phase snoop of the processor bus
   input wire logic I_RSP_VALID,
   input wire logic I_ERR_REC,
   input wire logic I_ERR_FATAL,
   input wire logic I_ERR_LPC_TIMEOUT,
   input wire logic I_ERR_LPC_SYNCH,
   input wire logic I_INITIATED,
   input wire logic I_WRITE,
   input wire logic I_READ,
   input wire logic I_SPECIAL,
   input wire logic I_CLEAN_LINE_REPLACE,
   input wire logic I_TRANSLATION_PURGE,
   input wire logic I_LINE_INVALIDATE,
   input wire logic I_DEFERRED,
   input wire logic I_SEQUENCING_SIGNAL,
   input wire logic I_MODIFIED_LINE_SNOOP_HIT,
   input wire logic I_RSP_HARDFAIL,
   input wire logic I_RSP_DEFER,
   input wire logic I_RSP_NODATA,
   input wire logic I_RSP_RETRY,
   input wire logic [2:0] I_DATA_LENGTH,
   input wire logic [7:0] I_BYTE_ENABLES,
   input wire logic I_TARGET_READY_SIGNAL,
   input wire logic [9:0] I_DEFERRED_TRANSACTION_ID,
   input wire logic [43:3] I_ADDR,
   input wire logic I_FWD_LINK_WRITE,
   input wire logic [43:3] I_LINK_PKT_ADDR,
   // Node-link protocol layer and configuration access errors
   input wire logic I_PROTO_ERR,
   input wire logic [63:0] I_PROTO_HEADER,
   // Releases from the first-error status register
   input wire logic I_REC_BUS_CLR,
   input wire logic I_FAT_BUS_CLR,
   input wire logic I_PROTO_CLR,
   // Configuration read port
   input wire logic I_CFG_RD,
   input wire logic [7:0] I_CFG_ADDR,
   output logic [31:0] O_CFG_RDATA,
   output logic O_REC_BUS_VALID,
   output logic O_FAT_BUS_VALID,
   output logic O_PROTO_VALID
);
   import errlog_pkg::*;

   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   initial begin
      if (BURST_CLR < 0 || BURST_CLR > BURST_CLR_MAX) $error("BURST_CLR out of range");
      if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 254) $error("SETTLE_CYCLES out of range");
   end

   // ----------------------------------------
   // Captured word assembly
   // ----------------------------------------
   logic [ADDR_W-1:0] addr_src;
   logic [ADDR_W-1:0] addr_mask;
   logic [ADDR_W-1:0] addr_log;
   logic [CTL_W-1:0] ctl_full;
   logic [BUS_LOG_W-1:0] word_full;
   logic [BUS_LOG_W-1:0] word_narrow;
   logic [BUS_LOG_W-1:0] rec_word;
   logic [BUS_LOG_W-1:0] fat_word;

   // Forwarded writes log the address of the outgoing link packet
   assign addr_src = I_FWD_LINK_WRITE ? I_LINK_PKT_ADDR : I_ADDR; // see RL9
   // Clearing low bits keeps the logged address burst aligned
   assign addr_mask = ~((ADDR_W'(1) << BURST_CLR) - ADDR_W'(1)); // see RL10
   assign addr_log = addr_src & addr_mask; // see RL8

   assign ctl_full = {
      I_INITIATED, I_WRITE, I_READ, I_SPECIAL,
      I_CLEAN_LINE_REPLACE, I_TRANSLATION_PURGE, I_LINE_INVALIDATE, // see RL4
      I_DEFERRED, I_SEQUENCING_SIGNAL, I_MODIFIED_LINE_SNOOP_HIT, // see RL5
      I_RSP_HARDFAIL, I_RSP_DEFER, I_RSP_NODATA, I_RSP_RETRY, // see RL6
      I_DATA_LENGTH, I_BYTE_ENABLES, I_TARGET_READY_SIGNAL, // see RL7
      I_DEFERRED_TRANSACTION_ID};

   // Reserved 95:77 stay zero in every captured word
   assign word_full = {19'h0, ctl_full, addr_log}; // see RL17

   // Only address, write and read for the LPC error kinds
   always_comb begin
      word_narrow = BUS_LOG_RESET;
      word_narrow[POS_WRITE] = I_WRITE;
      word_narrow[POS_READ] = I_READ;
      word_narrow[POS_ADDR_LO +: ADDR_W] = addr_log;
   end

   assign rec_word = I_ERR_LPC_TIMEOUT ? word_narrow : word_full; // see RL2
   assign fat_word = I_ERR_LPC_SYNCH ? word_narrow : word_full; // see RL12

   // ----------------------------------------
   // Capture registers
   // ----------------------------------------
   wire rec_load = I_RSP_VALID && I_ERR_REC;
   wire fat_load = I_RSP_VALID && I_ERR_FATAL;
   logic rec_full;
   logic fat_full;
   logic proto_full;
   logic fat_started;
   logic fat_ready;
   logic [BUS_LOG_W-1:0] rec_log;
   logic [BUS_LOG_W-1:0] fat_log;
   logic [PROTO_LOG_W-1:0] proto_log;

   errlog_capture #(.WIDTH(BUS_LOG_W)) u_rec_bus (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_load(rec_load), // see RL1
      .i_data(rec_word),
      .i_release(I_REC_BUS_CLR),
      .o_full(rec_full),
      .o_data(rec_log)
   );

   errlog_capture #(.WIDTH(BUS_LOG_W)) u_fat_bus (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_load(fat_load), // see RL11
      .i_data(fat_word),
      .i_release(I_FAT_BUS_CLR),
      .o_full(fat_full),
      .o_data(fat_log)
   );

   errlog_capture #(.WIDTH(PROTO_LOG_W)) u_proto (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_load(I_PROTO_ERR), // see RL14
      .i_data(I_PROTO_HEADER), // see RL15
      .i_release(I_PROTO_CLR),
      .o_full(proto_full),
      .o_data(proto_log)
   );

   // ----------------------------------------
   // Fatal log settling
   // ----------------------------------------
   assign fat_started = fat_load && !fat_full;

   errlog_settle #(.CYCLES(SETTLE_CYCLES)) u_settle (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_start(fat_started),
      .i_held(fat_full),
      .o_ready(fat_ready)
   );

   // ----------------------------------------
   // Validity and read port
   // ----------------------------------------
   assign O_REC_BUS_VALID = rec_full; // see RL3
   assign O_FAT_BUS_VALID = fat_ready; // see RL13
   assign O_PROTO_VALID = proto_full; // see RL3

   logic [31:0] rdata_next;
   logic [31:0] rdata_reg;

   // No write path: every field is read-only here, so writes cannot disturb logs
   always_comb begin
      case (I_CFG_ADDR)
         OFS_PROTO_LO: rdata_next = proto_log[31:0];
         OFS_PROTO_HI: rdata_next = proto_log[63:32];
         OFS_RECBUS_0: rdata_next = rec_log[31:0];
         OFS_RECBUS_1: rdata_next = rec_log[63:32];
         OFS_RECBUS_2: rdata_next = rec_log[95:64];
         OFS_FATBUS_0: rdata_next = fat_log[31:0];
         OFS_FATBUS_1: rdata_next = fat_log[63:32];
         OFS_FATBUS_2: rdata_next = fat_log[95:64];
         default: rdata_next = UNMAPPED_DATA;
      endcase
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         rdata_reg <= 32'h0;
      end else if (I_CFG_RD) begin
         rdata_reg <= rdata_next;
      end
   end
   assign O_CFG_RDATA = rdata_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // ----------------------------------------
   // Check helpers
   // ----------------------------------------
   // Age of the held fatal log; a counter keeps the settle checks cheap to unroll
   logic [7:0] fat_age_reg;
   logic [7:0] fat_age_next;

   assign fat_age_next = (fat_age_reg == 8'hff) ? fat_age_reg : fat_age_reg + 8'h1;

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N || !fat_full) begin
         fat_age_reg <= 8'h0;
      end else begin
         fat_age_reg <= fat_age_next;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_fat_capture;
      fat_load && !fat_full;
   endsequence

   sequence s_rec_wide;
      rec_load && !rec_full && !I_ERR_LPC_TIMEOUT;
   endsequence

   sequence s_fat_wide;
      fat_load && !fat_full && !I_ERR_LPC_SYNCH;
   endsequence

   sequence s_proto_capture;
      I_PROTO_ERR && !proto_full;
   endsequence

   a_fat_settle_wait: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL13
      s_fat_capture |=> !O_FAT_BUS_VALID [*8])
      else $error("fatal log valid too early");
   a_fat_settle_done: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL13
      fat_full && fat_age_reg >= 8'(SETTLE_CYCLES) |-> O_FAT_BUS_VALID)
      else $error("fatal log not valid after settle");
   a_fat_settle_hold: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL13
      fat_full && fat_age_reg < 8'(SETTLE_CYCLES) |-> !O_FAT_BUS_VALID)
      else $error("fatal log valid before settle");
   a_rec_capture: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL1
      rec_load && !rec_full |=> rec_log == $past(rec_word) && O_REC_BUS_VALID)
      else $error("recoverable log not captured");
   a_rec_type_bits: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL4
      s_rec_wide |=> rec_log[POS_INIT] == $past(I_INITIATED)
         && rec_log[POS_SPECIAL] == $past(I_SPECIAL)
         && rec_log[POS_TRANSLATION_PURGE] == $past(I_TRANSLATION_PURGE))
      else $error("transaction type bits misplaced");
   a_rec_defer_bits: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL5
      s_rec_wide |=> rec_log[POS_DEFERRED] == $past(I_DEFERRED)
         && rec_log[POS_SEQUENCING] == $past(I_SEQUENCING_SIGNAL)
         && rec_log[POS_MOD_HIT] == $past(I_MODIFIED_LINE_SNOOP_HIT))
      else $error("defer and snoop bits misplaced");
   a_rec_rsp_bits: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL6
      s_rec_wide |=> rec_log[POS_RSP_HARDFAIL] == $past(I_RSP_HARDFAIL)
         && rec_log[POS_RSP_NODATA] == $past(I_RSP_NODATA)
         && rec_log[POS_RSP_RETRY] == $past(I_RSP_RETRY))
      else $error("response bits misplaced");
   a_rec_len_fields: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL7
      s_rec_wide |=> rec_log[POS_LEN_LO +: 3] == $past(I_DATA_LENGTH)
         && rec_log[POS_BE_LO +: 8] == $past(I_BYTE_ENABLES)
         && rec_log[POS_TARGET_READY_SIGNAL] == $past(I_TARGET_READY_SIGNAL))
      else $error("length or enable fields misplaced");
   a_rec_addr_field: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL8
      rec_load && !rec_full && !I_FWD_LINK_WRITE && BURST_CLR == 0
      |=> rec_log[40:0] == $past(I_ADDR))
      else $error("logged address mismatch");
   a_rec_timeout_narrow: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL2
      rec_load && !rec_full && I_ERR_LPC_TIMEOUT
      |=> rec_log[POS_INIT] == 1'b0 && rec_log[POS_SPECIAL -: 14] == 14'h0)
      else $error("time-out log holds extra fields");
   a_fat_fields: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL11
      s_fat_wide |=> fat_log[POS_INIT] == $past(I_INITIATED)
         && fat_log[POS_DID_LO +: 10] == $past(I_DEFERRED_TRANSACTION_ID))
      else $error("fatal log fields misplaced");
   a_fat_synch_narrow: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL12
      fat_load && !fat_full && I_ERR_LPC_SYNCH
      |=> fat_log[POS_RSP_RETRY -: 12] == 12'h0 && fat_log[POS_WRITE] == $past(I_WRITE))
      else $error("synch log holds extra fields");
   a_reserved_zero: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL17
      rec_log[95:77] == 19'h0 && fat_log[95:77] == 19'h0)
      else $error("reserved log bits set");
   a_burst_low_zero: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL10
      (rec_log[3:0] & ~(4'hf << BURST_CLR)) == 4'h0
      && (fat_log[3:0] & ~(4'hf << BURST_CLR)) == 4'h0)
      else $error("burst address bits not cleared");
   a_proto_capture: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL15
      s_proto_capture |=> proto_log == $past(I_PROTO_HEADER))
      else $error("protocol log not captured");
   a_proto_valid: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL3
      s_proto_capture |=> O_PROTO_VALID)
      else $error("protocol log not flagged valid");
   a_proto_release: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL3
      proto_full && I_PROTO_CLR && !I_PROTO_ERR |=> !O_PROTO_VALID)
      else $error("protocol log still valid after release");
   a_rec_release: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL16
      rec_full && I_REC_BUS_CLR && !rec_load |=> !O_REC_BUS_VALID)
      else $error("recoverable log still valid after release");
   a_fwd_addr: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL9
      rec_load && !rec_full && I_FWD_LINK_WRITE && BURST_CLR == 0
      |=> rec_log[40:0] == $past(I_LINK_PKT_ADDR))
      else $error("forwarded address mismatch");
   a_read_order: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL4
      I_CFG_RD && I_CFG_ADDR == OFS_RECBUS_2 |=> O_CFG_RDATA == $past(rec_log[95:64]))
      else $error("read word mismatch");
   a_fat_read_word: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL11
      I_CFG_RD && I_CFG_ADDR == OFS_FATBUS_0 |=> O_CFG_RDATA == $past(fat_log[31:0]))
      else $error("fatal read word mismatch");
   a_proto_read_word: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL15
      I_CFG_RD && I_CFG_ADDR == OFS_PROTO_HI |=> O_CFG_RDATA == $past(proto_log[63:32]))
      else $error("protocol read word mismatch");
   a_unmapped_read: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // see RL17
      I_CFG_RD && I_CFG_ADDR == OFS_PROTO_HI + 8'h4 |=> O_CFG_RDATA == UNMAPPED_DATA)
      else $error("unmapped read not zero");
endmodule

//--- tb/cpu_bus_agent.sv
// Processor agent model that drives response-phase snoop fields.
// Assumes the bench calls issue() from its main sequence, one call at a time.
module cpu_bus_agent (
   input wire logic i_clk,
   output logic o_rsp_valid,
   output logic o_err_rec,
   output logic o_err_fatal,
   output logic o_lpc_timeout,
   output logic o_lpc_synch,
   output logic o_fwd,
   output logic [35:0] o_ctl,
   output logic [43:3] o_addr,
   output logic [43:3] o_pkt
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {o_rsp_valid, o_err_rec, o_err_fatal, o_lpc_timeout, o_lpc_synch, o_fwd} = 6'h0;
      o_ctl = 36'h0;
      o_addr = 41'h0;
      o_pkt = 41'h0;
   end
   // One response phase; fields turn to their inverse once it is over,
   // so a log that samples late picks up wrong data
   task automatic issue(input logic rec, fat, narrow, fwd, input logic [35:0] c,
                        input logic [43:3] a, p);
      @(posedge i_clk);
      {o_rsp_valid, o_err_rec, o_err_fatal} <= {1'b1, rec, fat};
      {o_lpc_timeout, o_lpc_synch, o_fwd} <= {narrow & rec, narrow & fat, fwd};
      o_ctl <= c;
      o_addr <= a;
      o_pkt <= p;
      @(posedge i_clk);
      {o_rsp_valid, o_err_rec, o_err_fatal, o_lpc_timeout, o_lpc_synch} <= 5'h0;
      o_ctl <= ~c;
      o_addr <= ~a;
      o_pkt <= ~p;
   endtask
endmodule

//--- tb/bus_error_capture_log_tb.sv
// Self-checking bench for the error capture logs.
// Assumes the default settle count; a second instance clears four low address bits.
module bus_error_capture_log_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import errlog_pkg::*;
   // ----------------------------------------
   // Stimulus and wiring
   // ----------------------------------------
   logic I_CLK = 1'b0, I_RST_N = 1'b0, cfg_rd = 1'b0, proto_err = 1'b0;
   logic rec_clr = 1'b0, fat_clr = 1'b0, pro_clr = 1'b0;
   logic [7:0] cfg_addr = 8'h0;
   logic [63:0] header = 64'h0;
   logic rv, er, ef, lt, ls, fw, rec_v, fat_v, pro_v;
   logic [35:0] c;
   logic [43:3] a, p;
   logic [31:0] rdata, rdata_al;
   int mismatches = 0, check_count = 0;
   localparam logic [35:0] C1 = 36'hfedcba987;
   localparam logic [43:3] A1 = 41'h1_5a5a_3c3c_f0, P1 = 41'h0_a5a5_c3c3_0f;
   localparam logic [63:0] H1 = 64'h0123_4567_89ab_cdef;
   initial forever #5 I_CLK = ~I_CLK;
   cpu_bus_agent cpu_bus_agent_i (.i_clk(I_CLK), .o_rsp_valid(rv), .o_err_rec(er),
      .o_err_fatal(ef), .o_lpc_timeout(lt), .o_lpc_synch(ls), .o_fwd(fw), .o_ctl(c),
      .o_addr(a), .o_pkt(p));
   bus_error_capture_log bus_error_capture_log_i (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
      .I_RSP_VALID(rv), .I_ERR_REC(er), .I_ERR_FATAL(ef), .I_ERR_LPC_TIMEOUT(lt),
      .I_ERR_LPC_SYNCH(ls), .I_INITIATED(c[35]), .I_WRITE(c[34]), .I_READ(c[33]),
      .I_SPECIAL(c[32]), .I_CLEAN_LINE_REPLACE(c[31]), .I_TRANSLATION_PURGE(c[30]),
      .I_LINE_INVALIDATE(c[29]), .I_DEFERRED(c[28]), .I_SEQUENCING_SIGNAL(c[27]),
      .I_MODIFIED_LINE_SNOOP_HIT(c[26]), .I_RSP_HARDFAIL(c[25]), .I_RSP_DEFER(c[24]),
      .I_RSP_NODATA(c[23]), .I_RSP_RETRY(c[22]), .I_DATA_LENGTH(c[21:19]),
      .I_BYTE_ENABLES(c[18:11]), .I_TARGET_READY_SIGNAL(c[10]),
      .I_DEFERRED_TRANSACTION_ID(c[9:0]), .I_ADDR(a), .I_FWD_LINK_WRITE(fw),
      .I_LINK_PKT_ADDR(p), .I_PROTO_ERR(proto_err), .I_PROTO_HEADER(header),
      .I_REC_BUS_CLR(rec_clr), .I_FAT_BUS_CLR(fat_clr), .I_PROTO_CLR(pro_clr),
      .I_CFG_RD(cfg_rd), .I_CFG_ADDR(cfg_addr), .O_CFG_RDATA(rdata),
      .O_REC_BUS_VALID(rec_v), .O_FAT_BUS_VALID(fat_v), .O_PROTO_VALID(pro_v));
   // Same stimulus, burst-aligned logged address
   bus_error_capture_log #(.BURST_CLR(BURST_CLR_MAX)) bus_error_capture_log_aligned_i (
      .I_CLK(I_CLK), .I_RST_N(I_RST_N),
      .I_RSP_VALID(rv), .I_ERR_REC(er), .I_ERR_FATAL(ef), .I_ERR_LPC_TIMEOUT(lt),
      .I_ERR_LPC_SYNCH(ls), .I_INITIATED(c[35]), .I_WRITE(c[34]), .I_READ(c[33]),
      .I_SPECIAL(c[32]), .I_CLEAN_LINE_REPLACE(c[31]), .I_TRANSLATION_PURGE(c[30]),
      .I_LINE_INVALIDATE(c[29]), .I_DEFERRED(c[28]), .I_SEQUENCING_SIGNAL(c[27]),
      .I_MODIFIED_LINE_SNOOP_HIT(c[26]), .I_RSP_HARDFAIL(c[25]), .I_RSP_DEFER(c[24]),
      .I_RSP_NODATA(c[23]), .I_RSP_RETRY(c[22]), .I_DATA_LENGTH(c[21:19]),
      .I_BYTE_ENABLES(c[18:11]), .I_TARGET_READY_SIGNAL(c[10]),
      .I_DEFERRED_TRANSACTION_ID(c[9:0]), .I_ADDR(a), .I_FWD_LINK_WRITE(fw),
      .I_LINK_PKT_ADDR(p), .I_PROTO_ERR(proto_err), .I_PROTO_HEADER(header),
      .I_REC_BUS_CLR(rec_clr), .I_FAT_BUS_CLR(fat_clr), .I_PROTO_CLR(pro_clr),
      .I_CFG_RD(cfg_rd), .I_CFG_ADDR(cfg_addr), .O_CFG_RDATA(rdata_al),
      .O_REC_BUS_VALID(), .O_FAT_BUS_VALID(), .O_PROTO_VALID());
   // ----------------------------------------
   // Access and compare tasks
   // ----------------------------------------
   task automatic chk(input string n, input logic [31:0] e, s);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic rd(input logic [7:0] ad, input logic [31:0] e);
      @(posedge I_CLK);
      cfg_rd <= 1'b1;
      cfg_addr <= ad;
      @(posedge I_CLK);
      cfg_rd <= 1'b0;
      #1 chk($sformatf("cfg word %h", ad), e, rdata);
   endtask
   // Narrow captures keep only write and read among the control flags
   task automatic rd_bus(input logic [7:0] b, input logic nar, input logic [35:0] cv,
                         input logic [43:3] av);
      logic [95:0] e;
      e = {19'h0, nar ? (cv & 36'h600000000) : cv, av};
      rd(b, e[31:0]);
      rd(b + 8'h4, e[63:32]);
      rd(b + 8'h8, e[95:64]);
   endtask
   task automatic clr(input logic [2:0] m);
      @(posedge I_CLK);
      {rec_clr, fat_clr, pro_clr} <= m;
      @(posedge I_CLK);
      {rec_clr, fat_clr, pro_clr} <= 3'h0;
      #1 chk("valid flags after release", 32'h0, {29'h0, rec_v, fat_v, pro_v});
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge I_CLK);
      mismatches++;
      report_and_stop;
   end
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge I_CLK);
      I_RST_N <= 1'b1;
      rd_bus(OFS_RECBUS_0, 1'b0, 36'h0, 41'h0);
      rd_bus(OFS_FATBUS_0, 1'b0, 36'h0, 41'h0);
      rd(OFS_PROTO_LO, 32'h0);
      rd(8'h48, UNMAPPED_DATA);
      cpu_bus_agent_i.issue(1'b1, 1'b0, 1'b0, 1'b0, C1, A1, P1);
      #1 chk("recoverable valid", 32'h1, {31'h0, rec_v});
      rd_bus(OFS_RECBUS_0, 1'b0, C1, A1);
      cpu_bus_agent_i.issue(1'b1, 1'b0, 1'b0, 1'b0, ~C1, ~A1, P1);
      rd_bus(OFS_RECBUS_0, 1'b0, C1, A1);
      clr(3'h4);
      cpu_bus_agent_i.issue(1'b1, 1'b0, 1'b0, 1'b1, ~C1, A1, P1);
      rd_bus(OFS_RECBUS_0, 1'b0, ~C1, P1);
      rd(OFS_RECBUS_0, P1[34:3]);
      chk("aligned address word", P1[34:3] & 32'hffff_fff0, rdata_al);
      clr(3'h4);
      cpu_bus_agent_i.issue(1'b1, 1'b0, 1'b1, 1'b0, ~C1, A1, P1);
      rd_bus(OFS_RECBUS_0, 1'b1, ~C1, A1);
      cpu_bus_agent_i.issue(1'b0, 1'b1, 1'b0, 1'b0, C1, A1, P1);
      repeat (FATAL_SETTLE_CYC - 1) @(posedge I_CLK);
      #1 chk("fatal valid early", 32'h0, {31'h0, fat_v});
      @(posedge I_CLK);
      #1 chk("fatal valid settled", 32'h1, {31'h0, fat_v});
      rd_bus(OFS_FATBUS_0, 1'b0, C1, A1);
      clr(3'h6);
      cpu_bus_agent_i.issue(1'b0, 1'b1, 1'b1, 1'b0, ~C1, ~A1, P1);
      rd_bus(OFS_FATBUS_0, 1'b1, ~C1, ~A1);
      @(posedge I_CLK);
      header <= H1;
      proto_err <= 1'b1;
      @(posedge I_CLK);
      header <= ~H1;
      @(posedge I_CLK);
      proto_err <= 1'b0;
      #1 chk("protocol valid", 32'h1, {31'h0, pro_v});
      rd(OFS_PROTO_LO, H1[31:0]);
      rd(OFS_PROTO_HI, H1[63:32]);
      clr(3'h7);
      report_and_stop;
   end
endmodule
